// ---- core/bank_ram.sv ----
/*
 Display RAM of 32 columns by 4 rows with the output bank selector.
 Assumes a scan step pulse from the frame timing outside this block.
*/
`timescale 1ns/1ps
module bank_ram (
   input wire logic clock, // System clock
   input wire logic srst, // Synchronous reset
   input wire logic clockEnable, // Freezes all state when low
   input wire logic writeEnable, // Write one column
   input wire logic [4:0] writeCol, // Column written
   input wire logic [3:0] writeMask, // Rows written
   input wire logic [3:0] writeBits, // Row data
   input wire logic [1:0] driveMode, // Current drive mode
   input wire logic outputBank, // Output bank selection
   input wire logic scanStep, // Advance to next backplane
   output logic [31:0] segmentData, // Row shown on segments
   output logic [3:0] backplaneSel // One-hot active backplane
);
   logic [3:0] cells [0:lcd_wp_pkg::NUM_COLS-1];
   logic [1:0] phase;
   logic [1:0] lastPhase;
   logic [1:0] selRow;

   assign lastPhase = 2'(lcd_wp_pkg::rowsPerWord(driveMode) - 3'h1);
   assign selRow = 2'(phase + lcd_wp_pkg::bankBase(driveMode, outputBank));

   // Column writes, only masked rows change
   always_ff @(posedge clock) begin
      if (srst) begin
         for (int c = 0; c < lcd_wp_pkg::NUM_COLS; c++) begin
            cells[c] <= 4'h0;
         end
      end else if (clockEnable && writeEnable) begin
         for (int r = 0; r < lcd_wp_pkg::NUM_ROWS; r++) begin
            if (writeMask[r]) begin
               cells[writeCol][r] <= writeBits[r];
            end
         end
      end
   end

   // Multiplex phase; a mode change may leave it past the end
   always_ff @(posedge clock) begin
      if (srst) begin
         phase <= 2'h0;
      end else if (clockEnable) begin
         if (phase > lastPhase) begin
            phase <= 2'h0;
         end else if (scanStep) begin
            phase <= (phase == lastPhase) ? 2'h0 : 2'(phase + 2'h1);
         end
      end
   end

   // Backplane follows the phase, not the bank
   always_ff @(posedge clock) begin
      if (srst) begin
         backplaneSel <= 4'h0;
      end else if (clockEnable) begin
         backplaneSel <= 4'(4'h1 << phase);
      end
   end

   // Segment registers pick the selected row of every column
   for (genvar c = 0; c < lcd_wp_pkg::NUM_COLS; c++) begin : gSeg
      always_ff @(posedge clock) begin
         if (srst) begin
            segmentData[c] <= 1'b0;
         end else if (clockEnable) begin
            segmentData[c] <= cells[c][selRow];
         end
      end
   end
endmodule // bank_ram

// ---- core/byte_fifo.sv ----
/*
 Flip-flop FIFO with valid/ready on both sides and honest full/empty.
 Assumes one clock, synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic clock, // System clock
   input wire logic srst, // Synchronous reset
   input wire logic clockEnable, // Freezes all state when low
   input wire logic inValid, // Word offered
   output logic inReady, // Room for a word
   input wire logic [WIDTH-1:0] inData, // Word in
   output logic outValid, // Word available
   input wire logic outReady, // Drain takes the word
   output logic [WIDTH-1:0] outData // Oldest word
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [AW-1:0] wrIdx;
   logic [AW-1:0] rdIdx;
   logic [AW:0] count;
   logic push;
   logic pop;

   // Full and empty straight from the fill count
   assign inReady = count != (AW+1)'(DEPTH);
   assign outValid = count != '0;
   assign outData = store[rdIdx];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // Storage writes
   always_ff @(posedge clock) begin
      if (clockEnable && push) begin
         store[wrIdx] <= inData;
      end
   end

   // Indices wrap naturally; depth is a power of two
   always_ff @(posedge clock) begin
      if (srst) begin
         wrIdx <= '0;
         rdIdx <= '0;
         count <= '0;
      end else if (clockEnable) begin
         if (push) begin
            wrIdx <= AW'(wrIdx + 1'b1);
         end
         if (pop) begin
            rdIdx <= AW'(rdIdx + 1'b1);
         end
         if (push && !pop) begin
            count <= (AW+1)'(count + 1'b1);
         end else if (pop && !push) begin
            count <= (AW+1)'(count - 1'b1);
         end
      end
   end
endmodule // byte_fifo

// ---- core/lcd_i2c_write_path_bank_select.sv ----
/*
 Two-wire target receiver and display RAM write path with bank selection.
 Assumes bus pins already synchronous to clock; command decoding lives
 outside and returns pointer, subaddress, mode and bank values as ports.
*/
`timescale 1ns/1ps
module lcd_i2c_write_path_bank_select (
   input wire logic clock, // System clock, 10 MHz
   input wire logic srst, // Synchronous reset
   input wire logic clockEnable, // Freezes all state when low
   input wire logic sclIn, // Serial clock level
   input wire logic sdaIn, // Serial data level
   output logic sdaOut, // Data drive value, always low
   output logic sdaOe, // High while pulling data low
   input wire logic target_addr_select_pin, // Address bit 1 select
   input wire logic hw_subaddr_bit0_pin, // Hardware subaddress bit 0
   input wire logic hw_subaddr_bit1_pin, // Hardware subaddress bit 1
   input wire logic hw_subaddr_bit2_pin, // Hardware subaddress bit 2
   input wire logic [1:0] driveMode, // Static, 1:2, 1:3, 1:4
   input wire logic inputBank, // Input bank selection
   input wire logic outputBank, // Output bank selection
   input wire logic pointerLoad, // Load data pointer pulse
   input wire logic [4:0] pointerValue, // Pointer load value
   input wire logic subaddrLoad, // Load subaddress counter pulse
   input wire logic [2:0] subaddrValue, // Subaddress load value
   input wire logic ramHold, // Stalls RAM writes
   input wire logic scanStep, // Next backplane pulse
   output logic commandValid, // Command byte pulse
   output logic [7:0] commandByte, // Received command byte
   output logic [4:0] dataPointer, // Current data pointer
   output logic [2:0] subaddrCount, // Current subaddress counter
   output logic addressed, // Transfer addressed to us
   output logic [31:0] segmentData, // Row shown on segments
   output logic backplane_out_0, // Backplane 0 active
   output logic backplane_out_1, // Backplane 1 active
   output logic backplane_out_2, // Backplane 2 active
   output logic backplane_out_3 // Backplane 3 active
);
   lcd_wp_pkg::rxState_t rxState;
   logic sclPrev;
   logic sdaPrev;
   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;
   logic [3:0] bitCount;
   logic [7:0] shiftReg;
   logic byteDone;
   logic addrMatch;
   logic subMatch;
   logic ackWanted;
   logic [5:0] ptrSum;
   logic fifoInValid;
   logic fifoInReady;
   logic [lcd_wp_pkg::FIFO_WIDTH-1:0] fifoInData;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [lcd_wp_pkg::FIFO_WIDTH-1:0] fifoOutData;
   logic writerBusy;
   logic [lcd_wp_pkg::FIFO_WIDTH-1:0] entry;
   logic [3:0] wordIdx;
   logic [7:0] eData;
   logic [4:0] ePtr;
   logic eBank;
   logic [1:0] eMode;
   logic [4:0] firstBit;
   logic [7:0] shifted;
   logic [3:0] rawMask;
   logic [3:0] rawBits;
   logic [3:0] writeMask;
   logic [3:0] writeBits;
   logic [4:0] writeCol;
   logic writeEnable;
   logic lastWord;
   logic [3:0] bpSel;

   // Previous levels for edge and condition detection
   always_ff @(posedge clock) begin
      if (srst) begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else if (clockEnable) begin
         sclPrev <= sclIn;
         sdaPrev <= sdaIn;
      end
   end

   // Data moving while clock stays high is a condition, not a bit
   assign startCond = sclPrev && sclIn && sdaPrev && !sdaIn;
   assign stopCond = sclPrev && sclIn && !sdaPrev && sdaIn;
   assign sclRise = !sclPrev && sclIn;
   assign sclFall = sclPrev && !sclIn;
   assign byteDone = sclFall && bitCount == lcd_wp_pkg::BIT_LAST;

   // Address byte check, read bit must be zero
   assign addrMatch = shiftReg[7:2] == lcd_wp_pkg::ADDR_PREFIX
      && shiftReg[1] == target_addr_select_pin
      && !shiftReg[0];
   assign subMatch = subaddrCount ==
      {hw_subaddr_bit2_pin, hw_subaddr_bit1_pin, hw_subaddr_bit0_pin};

   // Acknowledge decision per phase
   always_comb begin
      case (rxState)
         lcd_wp_pkg::RX_ADDR: ackWanted = addrMatch;
         lcd_wp_pkg::RX_CMD: ackWanted = 1'b1;
         lcd_wp_pkg::RX_DATA: ackWanted = subMatch && fifoInReady;
         default: ackWanted = 1'b0;
      endcase
   end

   // Receiver phase; a start restarts address recognition, a stop returns to idle
   always_ff @(posedge clock) begin
      if (srst) begin
         rxState <= lcd_wp_pkg::RX_IDLE;
      end else if (clockEnable) begin
         if (startCond) begin
            rxState <= lcd_wp_pkg::RX_ADDR;
         end else if (stopCond) begin
            rxState <= lcd_wp_pkg::RX_IDLE;
         end else if (byteDone) begin
            case (rxState)
               lcd_wp_pkg::RX_ADDR: begin
                  rxState <= addrMatch ? lcd_wp_pkg::RX_CMD
                                       : lcd_wp_pkg::RX_IGNORE;
               end
               lcd_wp_pkg::RX_CMD: begin
                  if (!shiftReg[7]) begin
                     rxState <= lcd_wp_pkg::RX_DATA;
                  end
               end
               default: rxState <= rxState;
            endcase
         end
      end
   end

   // Bit shifter; partial bytes die with any condition
   always_ff @(posedge clock) begin
      if (srst) begin
         bitCount <= 4'h0;
         shiftReg <= 8'h00;
      end else if (clockEnable) begin
         if (startCond || stopCond) begin
            bitCount <= 4'h0;
         end else if (sclRise && bitCount < lcd_wp_pkg::BIT_LAST) begin
            shiftReg <= {shiftReg[6:0], sdaIn};
            bitCount <= 4'(bitCount + 4'h1);
         end else if (byteDone) begin
            bitCount <= lcd_wp_pkg::ACK_SLOT;
         end else if (sclFall && bitCount == lcd_wp_pkg::ACK_SLOT) begin
            bitCount <= 4'h0;
         end
      end
   end

   // Acknowledge drive, set on the falling edge after bit eight, held
   // through the whole ninth clock high, dropped on its falling edge
   always_ff @(posedge clock) begin
      if (srst) begin
         sdaOe <= 1'b0;
      end else if (clockEnable) begin
         if (startCond || stopCond) begin
            sdaOe <= 1'b0;
         end else if (byteDone) begin
            sdaOe <= ackWanted;
         end else if (sclFall && bitCount == lcd_wp_pkg::ACK_SLOT) begin
            sdaOe <= 1'b0;
         end
      end
   end

   // Only ever pulls low; never transmits data
   always_ff @(posedge clock) begin
      if (srst) begin
         sdaOut <= 1'b0;
      end else if (clockEnable) begin
         sdaOut <= 1'b0;
      end
   end

   // Addressed status for the outside command decoder
   always_ff @(posedge clock) begin
      if (srst) begin
         addressed <= 1'b0;
      end else if (clockEnable) begin
         if (startCond || stopCond) begin
            addressed <= 1'b0;
         end else if (byteDone && rxState == lcd_wp_pkg::RX_ADDR) begin
            addressed <= addrMatch;
         end
      end
   end

   // Command bytes go out whole; their meaning is decoded outside
   always_ff @(posedge clock) begin
      if (srst) begin
         commandValid <= 1'b0;
         commandByte <= 8'h00;
      end else if (clockEnable) begin
         commandValid <= byteDone && rxState == lcd_wp_pkg::RX_CMD;
         if (byteDone && rxState == lcd_wp_pkg::RX_CMD) begin
            commandByte <= shiftReg;
         end
      end
   end

   assign ptrSum = 6'({1'b0, dataPointer} + {2'b00, lcd_wp_pkg::wordsPerByte(driveMode)});

   // Pointer steps on every data byte, matched or not; load wins
   always_ff @(posedge clock) begin
      if (srst) begin
         dataPointer <= lcd_wp_pkg::PTR_RESET;
      end else if (clockEnable) begin
         if (pointerLoad) begin
            dataPointer <= pointerValue;
         end else if (byteDone && rxState == lcd_wp_pkg::RX_DATA) begin
            dataPointer <= ptrSum[4:0];
         end
      end
   end

   // Subaddress follows pointer overflow so cascades stay aligned
   always_ff @(posedge clock) begin
      if (srst) begin
         subaddrCount <= lcd_wp_pkg::SUB_RESET;
      end else if (clockEnable) begin
         if (subaddrLoad) begin
            subaddrCount <= subaddrValue;
         end else if (byteDone && rxState == lcd_wp_pkg::RX_DATA && ptrSum[5]) begin
            subaddrCount <= 3'(subaddrCount + 3'h1);
         end
      end
   end

   // Matched data byte enters the buffer with its own placement;
   // a full buffer refuses the byte and the controller sees no ack
   assign fifoInValid = byteDone && rxState == lcd_wp_pkg::RX_DATA && subMatch;
   assign fifoInData = {driveMode, inputBank, dataPointer, shiftReg};

   byte_fifo #(
      .WIDTH(lcd_wp_pkg::FIFO_WIDTH),
      .DEPTH(lcd_wp_pkg::FIFO_DEPTH)
   ) uFifo (
      .clock(clock),
      .srst(srst),
      .clockEnable(clockEnable),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(fifoInData),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   // Buffered entry fields
   assign eData = entry[lcd_wp_pkg::FW_DATA_LSB +: 8];
   assign ePtr = entry[lcd_wp_pkg::FW_PTR_LSB +: lcd_wp_pkg::COL_W];
   assign eBank = entry[lcd_wp_pkg::FW_BANK_BIT];
   assign eMode = entry[lcd_wp_pkg::FW_MODE_LSB +: 2];
   assign fifoOutReady = !writerBusy;
   assign writeEnable = writerBusy && !ramHold;
   assign lastWord = wordIdx == 4'(lcd_wp_pkg::wordsPerByte(eMode) - 4'h1);

   // Writer: one column per cycle; the buffer only fills while ramHold stalls it
   always_ff @(posedge clock) begin
      if (srst) begin
         writerBusy <= 1'b0;
         entry <= '0;
         wordIdx <= 4'h0;
      end else if (clockEnable) begin
         if (!writerBusy && fifoOutValid) begin
            entry <= fifoOutData;
            writerBusy <= 1'b1;
            wordIdx <= 4'h0;
         end else if (writeEnable) begin
            wordIdx <= 4'(wordIdx + 4'h1);
            if (lastWord) begin
               writerBusy <= 1'b0;
            end
         end
      end
   end

   // Bits of this word, MSB first; the 1:3 tail word leaves row 2 alone
   always_comb begin
      firstBit = 5'(wordIdx * lcd_wp_pkg::rowsPerWord(eMode));
      shifted = 8'(eData << firstBit);
      rawMask = 4'h0;
      rawBits = 4'h0;
      for (int r = 0; r < lcd_wp_pkg::NUM_ROWS; r++) begin
         rawMask[r] = (r < int'(lcd_wp_pkg::rowsPerWord(eMode)))
            && (int'(firstBit) + r < 8);
         rawBits[r] = shifted[7-r];
      end
   end

   // Input bank moves static and 1:2 writes up to rows 2 and 3
   assign writeMask = 4'(rawMask << lcd_wp_pkg::bankBase(eMode, eBank));
   assign writeBits = 4'(rawBits << lcd_wp_pkg::bankBase(eMode, eBank));
   assign writeCol = 5'(ePtr + {1'b0, wordIdx});

   bank_ram uRam (
      .clock(clock),
      .srst(srst),
      .clockEnable(clockEnable),
      .writeEnable(writeEnable),
      .writeCol(writeCol),
      .writeMask(writeMask),
      .writeBits(writeBits),
      .driveMode(driveMode),
      .outputBank(outputBank),
      .scanStep(scanStep),
      .segmentData(segmentData),
      .backplaneSel(bpSel)
   );

   // Backplane bits are flops inside the RAM block
   assign backplane_out_0 = bpSel[0];
   assign backplane_out_1 = bpSel[1];
   assign backplane_out_2 = bpSel[2];
   assign backplane_out_3 = bpSel[3];
endmodule // lcd_i2c_write_path_bank_select

// ---- inc/lcd_wp_pkg.sv ----
/*
 Shared constants, state type and mode decoders for the two-wire write
 path and display RAM bank selection of the segment LCD driver.
 Assumes it is compiled before every file in core/.
*/
package lcd_wp_pkg;

   // Target address layout
   localparam logic [5:0] ADDR_PREFIX = 6'h1c;

   // Display RAM geometry
   localparam int NUM_COLS = 32;
   localparam int COL_W = 5;
   localparam int NUM_ROWS = 4;
   localparam int SUB_W = 3;
   localparam logic [1:0] ALT_BASE_ROW = 2'h2;
   localparam logic [1:0] MAIN_BASE_ROW = 2'h0;

   // Receive byte framing
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [3:0] ACK_SLOT = 4'h9;

   // Drive modes
   localparam logic [1:0] MODE_STATIC = 2'h0;
   localparam logic [1:0] MODE_MUX2 = 2'h1;
   localparam logic [1:0] MODE_MUX3 = 2'h2;
   localparam logic [1:0] MODE_MUX4 = 2'h3;

   // Buffer word layout: data, pointer, input bank, mode
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_WIDTH = 16;
   localparam int FW_DATA_LSB = 0;
   localparam int FW_PTR_LSB = 8;
   localparam int FW_BANK_BIT = 13;
   localparam int FW_MODE_LSB = 14;

   // Reset values
   localparam logic [4:0] PTR_RESET = 5'h00;
   localparam logic [2:0] SUB_RESET = 3'h0;

   typedef enum logic [4:0] {
      RX_IDLE = 5'h01,
      RX_ADDR = 5'h02,
      RX_CMD = 5'h04,
      RX_DATA = 5'h08,
      RX_IGNORE = 5'h10
   } rxState_t;

   // RAM words per byte, equal to the pointer step
   function automatic logic [3:0] wordsPerByte(input logic [1:0] mode);
      case (mode)
         MODE_STATIC: wordsPerByte = 4'h8;
         MODE_MUX2: wordsPerByte = 4'h4;
         MODE_MUX3: wordsPerByte = 4'h3;
         default: wordsPerByte = 4'h2;
      endcase
   endfunction

   // Rows per word, equal to backplanes scanned
   function automatic logic [2:0] rowsPerWord(input logic [1:0] mode);
      case (mode)
         MODE_STATIC: rowsPerWord = 3'h1;
         MODE_MUX2: rowsPerWord = 3'h2;
         MODE_MUX3: rowsPerWord = 3'h3;
         default: rowsPerWord = 3'h4;
      endcase
   endfunction

   // Bank switching exists only in static and two-backplane modes
   function automatic logic [1:0] bankBase(input logic [1:0] mode, input logic bank);
      if ((mode == MODE_STATIC || mode == MODE_MUX2) && bank)
         bankBase = ALT_BASE_ROW;
      else
         bankBase = MAIN_BASE_ROW;
   endfunction

endpackage

// ---- verif/bus_ctrl_model.sv ----
/*
 Bus controller model: serial clock, data bits and start/stop framing.
 Assumes the target pulls data low through its enable; pull-up wire.
*/
`timescale 1ns/1ps
module bus_ctrl_model (
   input wire logic clock, // System clock
   input wire logic sdaOe, // Target pulls low
   output logic scl, // Serial clock
   output logic sdaLine // Resolved data
);
   logic sdaDrv;
   // Pull-up: a released line reads high
   assign sdaLine = sdaDrv & ~sdaOe;
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end
   // Three cycles per level so the target sees every edge
   task automatic lvl(input logic c, input logic d);
      scl = c;
      sdaDrv = d;
      repeat (3) @(negedge clock);
   endtask
   // Also serves as repeated start
   task automatic startCond();
      lvl(scl, 1'b1);
      lvl(1'b1, 1'b1);
      lvl(1'b1, 1'b0);
      lvl(1'b0, 1'b0);
   endtask
   task automatic stopCond();
      lvl(1'b0, 1'b0);
      lvl(1'b1, 1'b0);
      lvl(1'b1, 1'b1);
   endtask
   // Data changes only while clock low; ack read at the end of clock-high
   task automatic sendByte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         lvl(1'b0, b[i]);
         lvl(1'b1, b[i]);
      end
      lvl(1'b0, 1'b1);
      lvl(1'b1, 1'b1);
      ack = ~sdaLine;
      lvl(1'b0, 1'b1);
   endtask
endmodule // bus_ctrl_model

// ---- verif/lcd_i2c_write_path_bank_select_tb.sv ----
/*
 Testbench for the write path: address, commands, data, banks, scan, buffer.
 Assumes the bus controller model and the bound port checker.
*/
`timescale 1ns/1ps
module lcd_i2c_write_path_bank_select_tb;
   logic clock, srst, clockEnable, scl, sdaLine, sdaOut, sdaOe, selPin, ack;
   logic inputBank, outputBank, pointerLoad, subaddrLoad, ramHold, scanStep;
   logic commandValid, addressed;
   logic [1:0] driveMode;
   logic [2:0] hwSub, subaddrValue, subaddrCount, sub;
   logic [3:0] bp;
   logic [4:0] pointerValue, dataPointer, ptr;
   logic [7:0] commandByte, d0, d1, cmd;
   logic [31:0] segmentData;
   int failures, tests_run, e;
   bus_ctrl_model ctl (.clock(clock), .sdaOe(sdaOe), .scl(scl), .sdaLine(sdaLine));
   lcd_i2c_write_path_bank_select dut_u (
      .clock(clock), .srst(srst), .clockEnable(clockEnable), .sclIn(scl), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .target_addr_select_pin(selPin),
      .hw_subaddr_bit0_pin(hwSub[0]), .hw_subaddr_bit1_pin(hwSub[1]),
      .hw_subaddr_bit2_pin(hwSub[2]), .driveMode(driveMode), .inputBank(inputBank),
      .outputBank(outputBank), .pointerLoad(pointerLoad), .pointerValue(pointerValue),
      .subaddrLoad(subaddrLoad), .subaddrValue(subaddrValue), .ramHold(ramHold),
      .scanStep(scanStep), .commandValid(commandValid), .commandByte(commandByte),
      .dataPointer(dataPointer), .subaddrCount(subaddrCount), .addressed(addressed),
      .segmentData(segmentData), .backplane_out_0(bp[0]), .backplane_out_1(bp[1]),
      .backplane_out_2(bp[2]), .backplane_out_3(bp[3]));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         failures++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Pointer step per byte for each drive mode
   function automatic int step(input logic [1:0] md);
      return (md == 2'h0) ? 8 : (md == 2'h1) ? 4 : (md == 2'h2) ? 3 : 2;
   endfunction
   // First received bit lands in the lowest column
   function automatic logic [7:0] rev(input logic [7:0] d);
      for (int k = 0; k < 8; k++)
         rev[k] = d[7 - k];
   endfunction
   // Stands in for the external command decoder
   task automatic load(input logic [4:0] p, input logic [2:0] s);
      {pointerValue, subaddrValue, pointerLoad, subaddrLoad} = {p, s, 2'h3};
      @(negedge clock);
      {pointerLoad, subaddrLoad} = 2'h0;
   endtask
   task automatic openWrite();
      ctl.startCond();
      ctl.sendByte({6'h1c, selPin, 1'b0}, ack);
      ctl.sendByte(8'h00, ack);
   endtask
   // A hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge clock);
      failures++;
      $display("mismatch at %0t: timeout", $time);
      tally_and_finish();
   end
   initial begin
      {failures, tests_run} = 0;
      {srst, clockEnable, selPin, inputBank, outputBank} = 5'h18;
      {pointerLoad, subaddrLoad, ramHold, scanStep} = 4'h0;
      {driveMode, pointerValue, subaddrValue} = 10'h000;
      e = $urandom(7505);
      hwSub = 3'($urandom);
      {d0, d1} = 16'($urandom);
      repeat (2) @(negedge clock);
      srst = 1'b0;
      // Static writes into both input banks, then every view
      load(5'h00, hwSub);
      openWrite();
      ctl.sendByte(d0, ack);
      inputBank = 1'b1;
      ctl.sendByte(d1, ack);
      ctl.stopCond();
      for (int k = 0; k < 8; k++) begin
         {driveMode, outputBank} = 3'(k);
         repeat (2) @(negedge clock);
         check(segmentData[15:0] === ((k[0] && k < 4) ? {rev(d1), 8'h00} : {8'h00, rev(d0)}),
            "bank view");
      end
      $display("test banks done");
      for (int md = 3; md >= 0; md--) begin
         driveMode = 2'(md);
         for (int k = 1; k <= md + 1; k++) begin
            scanStep = 1'b1;
            @(negedge clock);
            scanStep = 1'b0;
            repeat (2) @(negedge clock);
            check(bp === 4'(1 << (k % (md + 1))), "scan row");
         end
      end
      // Enable low freezes the phase although a step is offered
      {driveMode, clockEnable, scanStep} = 4'hd;
      repeat (2) @(negedge clock);
      {clockEnable, scanStep} = 2'h2;
      repeat (2) @(negedge clock);
      check(bp === 4'h1, "frozen scan");
      $display("test scan done");
      // Wrong select level and reads both refused, and later bytes too
      for (int i = 0; i < 4; i++) begin
         selPin = 1'($urandom);
         cmd = {1'b1, 7'($urandom)};
         ctl.startCond();
         ctl.sendByte({6'h1c, selPin ^ i[0], i[1]}, ack);
         check(ack === (i == 0), "address ack");
         check(addressed === (i == 0), "addressed");
         ctl.sendByte(cmd, ack);
         check(ack === (i == 0) && (i != 0 || commandByte === cmd), "command");
         ctl.stopCond();
      end
      $display("test address done");
      // Start near the top so the pointer wraps; odd modes start off-target
      for (int md = 0; md < 4; md++) begin
         driveMode = 2'(md);
         ptr = 5'h1c;
         sub = hwSub - 3'(md & 1);
         load(ptr, sub);
         openWrite();
         repeat (3) begin
            ctl.sendByte(8'($urandom), ack);
            check(ack === (sub == hwSub), "data ack");
            e = ptr + step(2'(md));
            sub = sub + 3'(e >> 5);
            ptr = 5'(e);
            check(dataPointer === ptr && subaddrCount === sub, "pointer");
         end
         ctl.stopCond();
      end
      $display("test pointer done");
      // Stalled writer: buffer fills and refuses, then drains
      ramHold = 1'b1;
      openWrite();
      for (int i = 0; i < 34; i++) begin
         load(5'h00, hwSub);
         ctl.sendByte(8'($urandom), ack);
         // Stalled writer holds one byte, the buffer 32 more
         check(ack === (i < 33), "buffer room");
      end
      ramHold = 1'b0;
      repeat (200) @(negedge clock);
      load(5'h00, hwSub);
      ctl.sendByte(8'($urandom), ack);
      check(ack === 1'b1, "buffer drained");
      ctl.stopCond();
      $display("test buffer done");
      tally_and_finish();
   end
endmodule // lcd_i2c_write_path_bank_select_tb

// ---- verif/lcd_wp_asserts.sv ----
/*
 Port checker for the two-wire write path, bound to its top module.
 Assumes clockEnable drops only while the bus is idle.
*/
`timescale 1ns/1ps
module lcd_wp_asserts (
   input wire logic clock, // Clock
   input wire logic srst, // Reset
   input wire logic sclIn, // Bus clock
   input wire logic sdaOut, // Drive value
   input wire logic sdaOe, // Pull enable
   input wire logic subaddrLoad, // Sub load
   input wire logic commandValid, // Command pulse
   input wire logic [4:0] dataPointer, // Pointer
   input wire logic [2:0] subaddrCount, // Sub counter
   input wire logic addressed, // Addressed flag
   input wire logic backplane_out_0, // Backplane 0
   input wire logic backplane_out_1, // Backplane 1
   input wire logic backplane_out_2, // Backplane 2
   input wire logic backplane_out_3 // Backplane 3
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // Open drain, so the drive value never goes high
   a_drive_low: assert property (sdaOut == 1'b0)
      else $error("data drive value not low");
   // Ack starts one cycle after the eighth clock falls
   a_ack_rise: assert property ($rose(sdaOe) |-> !$past(sclIn) && $past(sclIn, 2))
      else $error("ack rose at wrong moment");
   // Held across the whole clock-high period
   a_ack_hold: assert property (sdaOe && sclIn |=> sdaOe)
      else $error("ack dropped while clock high");
   a_ack_fall: assert property ($fell(sdaOe) |-> !$past(sclIn) && $past(sclIn, 2))
      else $error("ack fell at wrong moment");
   a_ack_addr: assert property (sdaOe |-> addressed)
      else $error("ack while not addressed");
   a_cmd_pulse: assert property (commandValid |-> $rose(sdaOe) ##1 !commandValid)
      else $error("command pulse not paired with ack");
   // Counter moves only on load or on pointer wrap
   a_sub_carry: assert property ($changed(subaddrCount) && !$past(subaddrLoad) && !$past(srst)
      |-> subaddrCount == $past(subaddrCount) + 3'h1 && dataPointer < $past(dataPointer))
      else $error("subaddress moved without wrap");
   a_bp_onehot: assert property (!$past(srst) && !$past(srst, 2)
      |-> $onehot({backplane_out_3, backplane_out_2, backplane_out_1, backplane_out_0}))
      else $error("backplanes not one-hot");
endmodule // lcd_wp_asserts

bind lcd_i2c_write_path_bank_select lcd_wp_asserts chk_u (.clock, .srst, .sclIn, .sdaOut,
   .sdaOe, .subaddrLoad, .commandValid, .dataPointer, .subaddrCount, .addressed,
   .backplane_out_0, .backplane_out_1, .backplane_out_2, .backplane_out_3);
